// ===== core/asd_pkg.sv
/*
 constants and types for the diagnostic and string command interpreter.
 assumes a single 100 MHz clock domain.
*/
package asd_pkg;
    localparam logic [7:0] CMD_READ_EXT2 = 8'h38;
    localparam logic [7:0] CMD_READ_IO = 8'h18;
    localparam logic [7:0] CMD_GET_FAULTS = 8'h3e;
    localparam logic [7:0] CMD_WRITE_PARAM = 8'h40;
    localparam logic [7:0] CMD_READ_PARAM = 8'h41;
    localparam logic [7:0] CMD_READ_IDSTR = 8'h42;
    localparam logic [7:0] CMD_READ_DIAG = 8'h43;
    localparam int JOB_MAX = 223;
    localparam int RESP_MAX = 221;
    localparam int STR_MAX = 220;
    localparam int FAULT_BYTES = 14;
    localparam int FAULT_USED = 8;
    localparam logic [1:0] ST_OK = 2'h0;
    localparam logic [1:0] ST_BAD_CMD = 2'h1;
    localparam logic [1:0] ST_TOO_LONG = 2'h2;
    localparam logic [1:0] LINK_EXT2 = 2'h0;
    localparam logic [1:0] LINK_IO = 2'h1;
    localparam logic [1:0] LINK_STR = 2'h2;
    typedef enum logic [2:0] {
        ASD_IDLE = 3'b000,
        ASD_ADDR = 3'b001,
        ASD_COUNT = 3'b011,
        ASD_SEND = 3'b010,
        ASD_WAIT = 3'b110,
        ASD_RECV = 3'b111,
        ASD_EMIT = 3'b101,
        ASD_DONE = 3'b100
    } asd_state_type;
endpackage : asd_pkg

// ===== core/asd_buf2.sv
/*
 two-entry buffer with valid and ready on both sides.
 assumes synchronous reset release from the parent.
*/
`timescale 1ns/1ps
`default_nettype none
module asd_buf2 #(
    parameter int WIDTH = 9
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [WIDTH-1:0] mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;
    assign push = in_valid && (count != 2'h2);
    assign pop = out_valid && out_ready;
    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule : asd_buf2
`default_nettype wire

// ===== core/asd_interp.sv
/*
 diagnostic and string command interpreter: takes a job byte stream,
 talks to slaves over a byte-level cable port, returns response bytes
 through a two-entry buffer. assumes the cable engine performs the
 framing and that jobs arrive one byte per accepted beat, last marked.
*/
`timescale 1ns/1ps
`default_nettype none
module asd_interp #(
    parameter int SLAVES = 64
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] job_data,
    input wire logic job_valid,
    input wire logic job_last,
    output logic job_ready,
    output logic [7:0] resp_data,
    output logic resp_last,
    output logic resp_valid,
    input wire logic resp_ready,
    output logic done,
    output logic [1:0] status,
    output logic link_req,
    output logic [1:0] link_kind,
    output logic link_read,
    output logic [5:0] link_addr,
    output logic [7:0] link_wdata,
    output logic link_wvalid,
    input wire logic link_wready,
    input wire logic [7:0] link_rdata,
    input wire logic link_rvalid,
    input wire logic link_rlast,
    input wire logic link_done,
    input wire logic fault_upd,
    input wire logic [5:0] fault_slave,
    input wire logic fault_bit,
    output logic [SLAVES-1:0] cyclic_hold
);
    logic rst_m;
    logic rst_s;
    asd_pkg::asd_state_type state;
    logic [7:0] cmd;
    logic [7:0] count;
    logic [7:0] idx;
    logic [7:0] rx_len;
    logic [7:0] str_mem [asd_pkg::RESP_MAX];
    logic [SLAVES-1:0] peripheral_fault_list;
    logic [7:0] bin_data;
    logic bin_last;
    logic bin_valid;
    logic bin_ready;
    logic [7:0] emit_byte;
    logic known;
    logic is_str_read;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_m <= 1'b0;
            rst_s <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_s <= rst_m;
        end
    end
    assign known = (job_data == asd_pkg::CMD_READ_EXT2) || (job_data == asd_pkg::CMD_READ_IO)
        || (job_data == asd_pkg::CMD_GET_FAULTS) || (job_data == asd_pkg::CMD_WRITE_PARAM)
        || (job_data == asd_pkg::CMD_READ_PARAM) || (job_data == asd_pkg::CMD_READ_IDSTR)
        || (job_data == asd_pkg::CMD_READ_DIAG);
    assign is_str_read = (cmd == asd_pkg::CMD_READ_PARAM) || (cmd == asd_pkg::CMD_READ_IDSTR)
        || (cmd == asd_pkg::CMD_READ_DIAG);
    always_ff @(posedge clock or negedge rst_s) begin
        if (!rst_s) begin
            peripheral_fault_list <= '0;
        end else if (fault_upd && (32'(fault_slave) < SLAVES)) begin
            peripheral_fault_list[fault_slave] <= fault_bit;
        end
    end
    always_comb begin
        emit_byte = 8'h00;
        if (cmd == asd_pkg::CMD_GET_FAULTS) begin
            if (idx < 8'(asd_pkg::FAULT_USED)) begin
                for (int b = 0; b < 8; b++) begin
                    if ((32'(idx) * 8 + b) < SLAVES) begin
                        emit_byte[7-b] = peripheral_fault_list[32'(idx) * 8 + b];
                    end
                end
            end
        end else if (idx == 8'h00) begin
            emit_byte = is_str_read ? rx_len : {4'h0, rx_len[3:0]};
        end else begin
            emit_byte = str_mem[idx - 8'h01];
        end
    end
    assign job_ready = (state == asd_pkg::ASD_IDLE) || (state == asd_pkg::ASD_ADDR)
        || (state == asd_pkg::ASD_COUNT) || ((state == asd_pkg::ASD_SEND) && link_wready);
    always_ff @(posedge clock or negedge rst_s) begin
        if (!rst_s) begin
            state <= asd_pkg::ASD_IDLE;
            cmd <= 8'h00;
            count <= 8'h00;
            idx <= 8'h00;
            rx_len <= 8'h00;
            done <= 1'b0;
            status <= asd_pkg::ST_OK;
            link_req <= 1'b0;
            link_kind <= asd_pkg::LINK_EXT2;
            link_read <= 1'b0;
            link_addr <= 6'h00;
            bin_valid <= 1'b0;
            bin_data <= 8'h00;
            bin_last <= 1'b0;
            cyclic_hold <= '0;
        end else begin
            done <= 1'b0;
            link_req <= 1'b0;
            if (bin_valid && bin_ready) begin
                bin_valid <= 1'b0;
            end
            case (state)
                asd_pkg::ASD_IDLE: begin
                    if (job_valid) begin
                        cmd <= job_data;
                        idx <= 8'h00;
                        rx_len <= 8'h00;
                        if (!known) begin
                            status <= asd_pkg::ST_BAD_CMD;
                            state <= asd_pkg::ASD_DONE;
                        end else if (job_data == asd_pkg::CMD_GET_FAULTS) begin
                            count <= 8'(asd_pkg::FAULT_BYTES);
                            state <= asd_pkg::ASD_EMIT;
                        end else begin
                            state <= asd_pkg::ASD_ADDR;
                        end
                    end
                end
                asd_pkg::ASD_ADDR: begin
                    if (job_valid) begin
                        link_addr <= job_data[5:0];
                        link_read <= (cmd != asd_pkg::CMD_WRITE_PARAM);
                        link_kind <= (cmd == asd_pkg::CMD_READ_EXT2) ? asd_pkg::LINK_EXT2 :
                            (cmd == asd_pkg::CMD_READ_IO) ? asd_pkg::LINK_IO : asd_pkg::LINK_STR;
                        if (cmd == asd_pkg::CMD_WRITE_PARAM) begin
                            state <= asd_pkg::ASD_COUNT;
                        end else begin
                            link_req <= 1'b1;
                            if (is_str_read && (32'(job_data[5:0]) < SLAVES)) begin
                                cyclic_hold[job_data[5:0]] <= 1'b1;
                            end
                            state <= asd_pkg::ASD_RECV;
                        end
                    end
                end
                asd_pkg::ASD_COUNT: begin
                    if (job_valid) begin
                        count <= job_data;
                        link_req <= 1'b1;
                        if (32'(link_addr) < SLAVES) begin
                            cyclic_hold[link_addr] <= 1'b1;
                        end
                        state <= (job_data == 8'h00) ? asd_pkg::ASD_WAIT : asd_pkg::ASD_SEND;
                    end
                end
                asd_pkg::ASD_SEND: begin
                    if (job_valid && link_wready) begin
                        count <= count - 8'h01;
                        if (count == 8'h01) begin
                            state <= asd_pkg::ASD_WAIT;
                        end
                    end
                end
                asd_pkg::ASD_WAIT: begin
                    if (link_done) begin
                        count <= 8'h00;
                        state <= asd_pkg::ASD_EMIT;
                    end
                end
                asd_pkg::ASD_RECV: begin
                    if (link_rvalid) begin
                        if (is_str_read && (rx_len == 8'(asd_pkg::STR_MAX))) begin
                            status <= asd_pkg::ST_TOO_LONG;
                            state <= asd_pkg::ASD_DONE;
                        end else begin
                            if (is_str_read) begin
                                str_mem[rx_len] <= link_rdata;
                                rx_len <= rx_len + 8'h01;
                            end else begin
                                rx_len <= link_rdata;
                            end
                            if (link_rlast) begin
                                count <= is_str_read ? rx_len + 8'h02 : 8'h01;
                                state <= asd_pkg::ASD_EMIT;
                            end
                        end
                    end
                end
                asd_pkg::ASD_EMIT: begin
                    if (!bin_valid || bin_ready) begin
                        if (idx == count) begin
                            status <= asd_pkg::ST_OK;
                            state <= asd_pkg::ASD_DONE;
                        end else begin
                            bin_valid <= 1'b1;
                            bin_data <= emit_byte;
                            bin_last <= (idx + 8'h01 == count);
                            idx <= idx + 8'h01;
                        end
                    end
                end
                asd_pkg::ASD_DONE: begin
                    if (!job_valid || !job_last) begin
                        done <= 1'b1;
                        cyclic_hold <= '0;
                        state <= asd_pkg::ASD_IDLE;
                    end
                end
                default: begin
                    state <= asd_pkg::ASD_IDLE;
                end
            endcase
        end
    end
    assign link_wdata = job_data;
    assign link_wvalid = (state == asd_pkg::ASD_SEND) && job_valid;
    logic [8:0] bout;
    asd_buf2 #(
        .WIDTH(9)
    ) u_asd_buf2 (
        .clock(clock),
        .rst_n(rst_s),
        .in_data({bin_last, bin_data}),
        .in_valid(bin_valid),
        .in_ready(bin_ready),
        .out_data(bout),
        .out_valid(resp_valid),
        .out_ready(resp_ready)
    );
    assign resp_data = bout[7:0];
    assign resp_last = bout[8];
    property p_bad_cmd;
        @(posedge clock) disable iff (!rst_s)
        (state == asd_pkg::ASD_IDLE && job_valid && !known) |=> !link_req [*2];
    endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("unknown code reached cable");
    property p_too_long;
        @(posedge clock) disable iff (!rst_s)
        (state == asd_pkg::ASD_RECV && link_rvalid && is_str_read
            && rx_len == 8'(asd_pkg::STR_MAX)) |=> (status == asd_pkg::ST_TOO_LONG) && !bin_valid;
    endproperty
    a_too_long: assert property (p_too_long) else $error("long string not aborted");
    property p_hold;
        @(posedge clock) disable iff (!rst_s)
        (state == asd_pkg::ASD_SEND || (state == asd_pkg::ASD_RECV && is_str_read))
            |-> cyclic_hold[link_addr];
    endproperty
    a_hold: assert property (p_hold) else $error("cyclic exchange not held");
    property p_fault;
        @(posedge clock) disable iff (!rst_s)
        (fault_upd && fault_slave == 6'h00) |=> peripheral_fault_list[0] == $past(fault_bit);
    endproperty
    a_fault: assert property (p_fault) else $error("fault list not refreshed");
    property p_fwd;
        @(posedge clock) disable iff (!rst_s)
        (state == asd_pkg::ASD_RECV && link_rvalid && is_str_read
            && rx_len != 8'(asd_pkg::STR_MAX))
            |=> str_mem[$past(rx_len)] == $past(link_rdata);
    endproperty
    a_fwd: assert property (p_fwd) else $error("string byte altered");
    property p_count;
        @(posedge clock) disable iff (!rst_s)
        (state == asd_pkg::ASD_SEND && job_valid && link_wready && count == 8'h01)
            |=> state == asd_pkg::ASD_WAIT;
    endproperty
    a_count: assert property (p_count) else $error("byte count not honoured");
endmodule : asd_interp
`default_nettype wire

// ===== tb/asd_slave_model.sv
/*
 cable-side slave model: answers reads with a byte stream, takes write
 bytes with stalls. assumes the byte-level cable port of asd_interp.
*/
`timescale 1ns/1ps
`default_nettype none
module asd_slave_model (
    input wire logic clock,
    input wire logic link_req,
    input wire logic link_read,
    input wire logic [7:0] link_wdata,
    input wire logic link_wvalid,
    output logic link_wready,
    output logic [7:0] link_rdata,
    output logic link_rvalid,
    output logic link_rlast,
    output logic link_done,
    input wire logic [31:0] rlen,
    input wire logic [31:0] wlen,
    input wire logic [7:0] rbase
);
    logic [7:0] wq[$];
    int n;
    initial begin
        link_wready = 1'b0;
        link_rdata = 8'h5a;
        link_rvalid = 1'b0;
        link_rlast = 1'b0;
        link_done = 1'b0;
        forever begin
            @(posedge clock);
            if (link_req && link_read) begin
                repeat (2) @(posedge clock);
                for (int k = 0; k < rlen; k++) begin
                    link_rdata <= rbase + 8'(k);
                    link_rvalid <= 1'b1;
                    link_rlast <= (k == rlen - 1);
                    @(posedge clock);
                end
                link_rvalid <= 1'b0;
                link_rlast <= 1'b0;
                link_rdata <= ~link_rdata;
            end else if (link_req) begin
                n = 0;
                while (n < wlen) begin
                    link_wready <= ~link_wready;
                    @(posedge clock);
                    if (link_wvalid && link_wready) begin
                        wq.push_back(link_wdata);
                        n++;
                    end
                end
                link_wready <= 1'b0;
                link_done <= 1'b1;
                @(posedge clock);
                link_done <= 1'b0;
            end
        end
    end
endmodule : asd_slave_model
`default_nettype wire

// ===== tb/asd_interp_test.sv
/*
 self-checking bench for asd_interp with a slave model on the cable.
 assumes the package constants and the hand-over port timing.
*/
`timescale 1ns/1ps
`default_nettype none
module asd_interp_test;
    logic clock, rst_n, job_valid, job_last, resp_ready, fault_upd, fault_bit;
    logic job_ready, resp_last, resp_valid, done, link_req, link_read, link_wvalid;
    logic link_wready, link_rvalid, link_rlast, link_done, done_seen, rd_seen;
    logic [7:0] job_data, resp_data, link_wdata, link_rdata, rbase;
    logic [1:0] status, link_kind, st_seen, kind_seen;
    logic [5:0] link_addr, fault_slave, addr_seen;
    logic [63:0] cyclic_hold;
    logic [7:0] jq[$], eq[$], rq[$];
    int rlen, wlen, failures, tests_run, reqs, hold_bad, lastpos, cyc;
    asd_interp #(.SLAVES(64)) u_asd_interp (.clock, .rst_n, .job_data, .job_valid,
        .job_last, .job_ready, .resp_data, .resp_last, .resp_valid, .resp_ready, .done,
        .status, .link_req, .link_kind, .link_read, .link_addr, .link_wdata, .link_wvalid,
        .link_wready, .link_rdata, .link_rvalid, .link_rlast, .link_done, .fault_upd,
        .fault_slave, .fault_bit, .cyclic_hold);
    asd_slave_model u_asd_slave_model (.clock, .link_req, .link_read, .link_wdata,
        .link_wvalid, .link_wready, .link_rdata, .link_rvalid, .link_rlast, .link_done,
        .rlen, .wlen, .rbase);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        resp_ready <= (cyc % 4) != 3;
        if (resp_valid && resp_ready) begin
            rq.push_back(resp_data);
            if (resp_last) lastpos <= rq.size();
        end
        if (link_req) begin
            reqs <= reqs + 1;
            kind_seen <= link_kind;
            addr_seen <= link_addr;
            rd_seen <= link_read;
        end
        if ((link_wvalid && link_wready || link_rvalid) && link_kind == asd_pkg::LINK_STR
            && cyclic_hold[link_addr] !== 1'b1)
            hold_bad <= hold_bad + 1;
        if (done) begin
            done_seen <= 1'b1;
            st_seen <= status;
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task run(input logic [1:0] st, input int nreq, input string name);
        int r0;
        int w;
        r0 = reqs;
        rq.delete();
        lastpos = 0;
        done_seen = 1'b0;
        @(posedge clock);
        foreach (jq[i]) begin
            job_data <= jq[i];
            job_valid <= 1'b1;
            job_last <= (i == jq.size() - 1);
            do @(negedge clock); while (job_ready !== 1'b1);
            @(posedge clock);
        end
        job_valid <= 1'b0;
        w = 0;
        while (done_seen !== 1'b1 && w < 4000) begin
            @(posedge clock);
            w++;
        end
        repeat (8) @(posedge clock);
        check(done_seen, 1);
        check(st_seen, st);
        check(reqs - r0, nreq);
        check(rq.size(), eq.size());
        foreach (eq[i]) check(rq[i], eq[i]);
        if (eq.size() > 0) check(lastpos, eq.size());
        $display("test %s done", name);
    endtask : run
    task fault(input logic [5:0] s, input logic b);
        @(posedge clock);
        fault_upd <= 1'b1;
        fault_slave <= s;
        fault_bit <= b;
        @(posedge clock);
        fault_upd <= 1'b0;
    endtask : fault
    task t_ext2;
        rlen = 1;
        rbase = 8'hc5;
        jq = '{asd_pkg::CMD_READ_EXT2, 8'h07};
        eq = '{8'h05};
        run(asd_pkg::ST_OK, 1, "ext2");
        check(kind_seen, asd_pkg::LINK_EXT2);
        check(addr_seen, 6'h07);
    endtask : t_ext2
    task t_io;
        rbase = 8'h3a;
        jq = '{asd_pkg::CMD_READ_IO, 8'h21};
        eq = '{8'h0a};
        run(asd_pkg::ST_OK, 1, "io");
        check(kind_seen, asd_pkg::LINK_IO);
        check(rd_seen, 1);
    endtask : t_io
    task t_faults;
        fault(6'h00, 1'b1);
        fault(6'h09, 1'b1);
        fault(6'h21, 1'b1);
        fault(6'h3f, 1'b1);
        fault(6'h09, 1'b0);
        jq = '{asd_pkg::CMD_GET_FAULTS};
        eq = {};
        repeat (asd_pkg::FAULT_BYTES) eq.push_back(8'h00);
        eq[0] = 8'h80;
        eq[4] = 8'h40;
        eq[7] = 8'h01;
        run(asd_pkg::ST_OK, 0, "faults");
    endtask : t_faults
    task t_write;
        wlen = 3;
        jq = '{asd_pkg::CMD_WRITE_PARAM, 8'h05, 8'h03, 8'h11, 8'hee, 8'h00};
        eq = {};
        run(asd_pkg::ST_OK, 1, "write");
        check(u_asd_slave_model.wq.size(), 3);
        foreach (jq[i]) if (i > 2) check(u_asd_slave_model.wq[i - 3], jq[i]);
        check(kind_seen, asd_pkg::LINK_STR);
        check(rd_seen, 0);
        check(hold_bad, 0);
        check(cyclic_hold[5], 0);
        wlen = 0;
        jq = '{asd_pkg::CMD_WRITE_PARAM, 8'h06, 8'h00};
        run(asd_pkg::ST_OK, 1, "write0");
        check(u_asd_slave_model.wq.size(), 3);
        check(cyclic_hold[6], 0);
        check(hold_bad, 0);
    endtask : t_write
    task t_reads;
        logic [7:0] codes[3];
        int lens[3];
        codes = '{asd_pkg::CMD_READ_PARAM, asd_pkg::CMD_READ_IDSTR, asd_pkg::CMD_READ_DIAG};
        lens = '{3, 1, 2};
        for (int c = 0; c < 3; c++) begin
            rlen = lens[c];
            rbase = 8'h30 + 8'(c);
            jq = '{codes[c], 8'h12};
            eq = '{8'(lens[c])};
            for (int k = 0; k < lens[c]; k++) eq.push_back(rbase + 8'(k));
            run(asd_pkg::ST_OK, 1, "read");
        end
        check(hold_bad, 0);
    endtask : t_reads
    task t_long;
        rlen = asd_pkg::STR_MAX;
        rbase = 8'h00;
        jq = '{asd_pkg::CMD_READ_DIAG, 8'h02};
        eq = '{8'(rlen)};
        for (int k = 0; k < rlen; k++) eq.push_back(8'(k));
        run(asd_pkg::ST_OK, 1, "max");
        rlen = asd_pkg::STR_MAX + 1;
        eq = {};
        run(asd_pkg::ST_TOO_LONG, 1, "long");
    endtask : t_long
    task t_bad;
        logic [7:0] codes[3];
        codes = '{8'h55, 8'h44, 8'hff};
        eq = {};
        foreach (codes[c]) begin
            jq = '{codes[c]};
            run(asd_pkg::ST_BAD_CMD, 0, "bad");
        end
    endtask : t_bad
    task conclude;
        $display("counts: %0d compares, %0d mismatches", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    initial begin
        {rst_n, job_valid, job_last, fault_upd, fault_bit} = 5'h00;
        {job_data, rbase, fault_slave} = 22'h0;
        resp_ready = 1'b1;
        {rlen, wlen, failures, tests_run, reqs, hold_bad, cyc} = '0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        repeat (5) @(posedge clock);
        t_ext2;
        t_io;
        t_faults;
        t_write;
        t_reads;
        t_long;
        t_bad;
        conclude;
    end
    initial begin
        #200000;
        failures++;
        conclude;
    end
endmodule : asd_interp_test
`default_nettype wire
